// >>> shared/fast_gate_pkg.sv
// Constants for the fast address-gate and processor reset block.
// Assumes a single clock at 250 MHz; times are converted to cycle counts here.
package fast_gate_pkg;

  // Register locations
  localparam logic [7:0] SYS_PORT_ADDR     = 8'h92;
  localparam logic [7:0] FAST_CTRL_INDEX   = 8'hF0;
  localparam logic [3:0] FAST_CTRL_LDEV    = 4'h5;

  // Fast path control fields
  localparam int CLK_SEL_HI_BIT  = 7;
  localparam int CLK_SEL_LO_BIT  = 6;
  localparam int SYS_PORT_EN_BIT = 2;
  localparam int HW_GATE_EN_BIT  = 1;
  localparam int HW_RST_EN_BIT   = 0;
  localparam logic [7:0] FAST_CTRL_RESET = 8'h00;
  localparam logic [7:0] FAST_CTRL_WMASK = 8'hC7;

  // System control port fields
  localparam int SYS_GATE_BIT  = 1;
  localparam int SYS_PULL_BIT  = 0;
  localparam logic [7:0] SYS_PORT_RESET = 8'h24;
  localparam logic [7:0] SYS_PORT_FIXED = 8'h24;

  // Controller commands
  localparam logic [7:0] CMD_WRITE_OUT = 8'hD1;
  localparam logic [7:0] CMD_PULSE_RST = 8'hFE;

  // Clock-rate codes
  localparam logic [1:0] RATE_6MHZ  = 2'h0;
  localparam logic [1:0] RATE_8MHZ  = 2'h1;
  localparam logic [1:0] RATE_12MHZ = 2'h2;
  localparam logic [1:0] RATE_16MHZ = 2'h3;

  // Timing
  localparam int SYS_CLK_MHZ   = 250;
  localparam int DELAY_US      = 14;
  localparam int PULSE_US      = 6;
  localparam int CNT_W         = 16;
  localparam logic [CNT_W-1:0] DELAY_CYCLES = CNT_W'(DELAY_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(PULSE_US * SYS_CLK_MHZ);
  // Controller-clock ticks per microsecond for each rate code
  localparam logic [4:0] TICKS_6  = 5'd6;
  localparam logic [4:0] TICKS_8  = 5'd8;
  localparam logic [4:0] TICKS_12 = 5'd12;
  localparam logic [4:0] TICKS_16 = 5'd16;

  typedef enum logic [2:0]
  {
    PULSE_IDLE  = 3'b001,
    PULSE_WAIT  = 3'b010,
    PULSE_DRIVE = 3'b100
  } pulse_state_t;

endpackage : fast_gate_pkg

// >>> rtl/reset_pulser.sv
// Delayed reset pulse generator (pulse_o high while driving), counting controller clock ticks.
// Assumes tick_i is a one-cycle controller-clock enable on sys_clk_i.
`timescale 1ns/10ps
module reset_pulser
#(
  parameter logic [15:0] DELAY_TICKS = 16'd14,
  parameter logic [15:0] PULSE_TICKS = 16'd6
)
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        start_i,
  input  wire logic        tick_i,
  input  wire logic [4:0]  ticks_per_us_i,
  // Status
  output logic             pulse_o,
  output logic             busy_o
);
  typedef struct packed
  {
    fast_gate_pkg::pulse_state_t state;
    logic [4:0]                  sub;
    logic [15:0]                 us;
  } pulser_t;

  pulser_t cur;
  pulser_t next_cur;

  always_comb
  begin
    next_cur = cur;
    case (cur.state)
      fast_gate_pkg::PULSE_IDLE:
      begin
        if (start_i)
        begin
          next_cur.state = fast_gate_pkg::PULSE_WAIT;
          next_cur.sub   = 5'd0;
          next_cur.us    = 16'd0;
        end
      end
      default:
      begin
        // Microseconds are counted in whole controller-clock ticks, rounded up
        if (tick_i)
        begin
          if (cur.sub + 5'd1 >= ticks_per_us_i)
          begin
            next_cur.sub = 5'd0;
            next_cur.us  = cur.us + 16'd1;
          end
          else
          begin
            next_cur.sub = cur.sub + 5'd1;
          end
        end
        if (cur.state == fast_gate_pkg::PULSE_WAIT && cur.us >= DELAY_TICKS)
        begin
          next_cur.state = fast_gate_pkg::PULSE_DRIVE;
          next_cur.us    = 16'd0;
          next_cur.sub   = 5'd0;
        end
        else if (cur.state == fast_gate_pkg::PULSE_DRIVE && cur.us >= PULSE_TICKS)
        begin
          next_cur.state = fast_gate_pkg::PULSE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cur.state <= fast_gate_pkg::PULSE_IDLE;
      cur.sub   <= 5'd0;
      cur.us    <= 16'd0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign pulse_o = (cur.state == fast_gate_pkg::PULSE_DRIVE);
  assign busy_o  = (cur.state != fast_gate_pkg::PULSE_IDLE);

endmodule : reset_pulser

// >>> rtl/fast_gate_ctrl.sv
// Fast address-line-20 gate and processor reset logic of the keyboard controller.
// Assumes host writes arrive as one-cycle strobes on sys_clk_i, already decoded
// to controller data/command port, system control port and configuration index.
`timescale 1ns/10ps
module fast_gate_ctrl
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Controller clock from outside
  input  wire logic       kbc_clk_i,
  // Host write to controller ports
  input  wire logic       host_wr_i,
  input  wire logic       host_is_cmd_i,
  input  wire logic [7:0] host_data_i,
  // System control port access
  input  wire logic       sys_port_wr_i,
  input  wire logic [7:0] sys_port_wdata_i,
  output logic      [7:0] sys_port_rdata_o,
  // Configuration register access
  input  wire logic       cfg_wr_i,
  input  wire logic [3:0] cfg_ldev_i,
  input  wire logic [7:0] cfg_index_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  // Firmware path requests
  input  wire logic       fw_gate_i,
  input  wire logic       fw_reset_n_i,
  // Outputs
  output logic            addr20_gate_out_o,
  output logic            cpu_reset_out_n_o
);
  typedef struct packed
  {
    logic [7:0] fast_ctrl;
    logic [1:0] sys_bits;
    logic       await_d1_data;
    logic       hw_gate;
    logic       hw_reset_n;
    logic [2:0] clk_sync;
    logic       gate_out;
    logic       reset_out_n;
    logic [7:0] sys_rdata;
    logic [7:0] cfg_rdata;
  } ctrl_t;

  ctrl_t cur;
  ctrl_t next_cur;

  logic       kbc_tick;
  logic [4:0] ticks_per_us;
  logic       fe_start;
  logic       sys_start;
  logic       fe_pulse;
  logic       sys_pulse;
  logic       fe_busy;
  logic       sys_busy;
  logic       sys_en;
  logic       hw_gate_en;
  logic       hw_rst_en;

  assign sys_en     = cur.fast_ctrl[fast_gate_pkg::SYS_PORT_EN_BIT];
  assign hw_gate_en = cur.fast_ctrl[fast_gate_pkg::HW_GATE_EN_BIT];
  assign hw_rst_en  = cur.fast_ctrl[fast_gate_pkg::HW_RST_EN_BIT];
  // Rising edge of the synchronised controller clock; first stage is not read here
  assign kbc_tick   = cur.clk_sync[1] & ~cur.clk_sync[2];

  always_comb
  begin
    // Rate code decode
    case (cur.fast_ctrl[fast_gate_pkg::CLK_SEL_HI_BIT:fast_gate_pkg::CLK_SEL_LO_BIT])
      fast_gate_pkg::RATE_6MHZ:  ticks_per_us = fast_gate_pkg::TICKS_6;
      fast_gate_pkg::RATE_8MHZ:  ticks_per_us = fast_gate_pkg::TICKS_8;
      fast_gate_pkg::RATE_12MHZ: ticks_per_us = fast_gate_pkg::TICKS_12;
      default:                   ticks_per_us = fast_gate_pkg::TICKS_16;
    endcase
  end

  // FE command starts the pulser only when the hardware reset path is selected
  assign fe_start  = host_wr_i & host_is_cmd_i & hw_rst_en
                     & (host_data_i == fast_gate_pkg::CMD_PULSE_RST);
  // Pull bit rising with port enabled; host must clear it before the next one
  assign sys_start = sys_port_wr_i & sys_en
                     & sys_port_wdata_i[fast_gate_pkg::SYS_PULL_BIT]
                     & ~cur.sys_bits[fast_gate_pkg::SYS_PULL_BIT];

  reset_pulser u_fe_pulser
  (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .start_i        (fe_start),
    .tick_i         (kbc_tick),
    .ticks_per_us_i (ticks_per_us),
    .pulse_o        (fe_pulse),
    .busy_o         (fe_busy)
  );

  reset_pulser u_sys_pulser
  (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .start_i        (sys_start),
    .tick_i         (kbc_tick),
    .ticks_per_us_i (ticks_per_us),
    .pulse_o        (sys_pulse),
    .busy_o         (sys_busy)
  );

  always_comb
  begin
    logic kb_gate;
    logic kb_reset_n;
    logic sys_gate;
    logic sys_reset_n;
    kb_gate     = 1'b0;
    kb_reset_n  = 1'b1;
    sys_gate    = 1'b0;
    sys_reset_n = 1'b1;
    next_cur    = cur;
    next_cur.clk_sync = {cur.clk_sync[1:0], kbc_clk_i};

    // Configuration register, device 5 index F0
    if (cfg_wr_i && cfg_ldev_i == fast_gate_pkg::FAST_CTRL_LDEV
        && cfg_index_i == fast_gate_pkg::FAST_CTRL_INDEX)
    begin
      next_cur.fast_ctrl = cfg_wdata_i & fast_gate_pkg::FAST_CTRL_WMASK;
    end
    if (cfg_ldev_i == fast_gate_pkg::FAST_CTRL_LDEV
        && cfg_index_i == fast_gate_pkg::FAST_CTRL_INDEX)
    begin
      next_cur.cfg_rdata = cur.fast_ctrl;
    end
    else
    begin
      next_cur.cfg_rdata = 8'h00;
    end

    // System control port writes land only in the two live bits
    if (sys_port_wr_i)
    begin
      next_cur.sys_bits = sys_port_wdata_i[1:0];
    end
    next_cur.sys_rdata = fast_gate_pkg::SYS_PORT_FIXED | {6'h00, cur.sys_bits};

    // Data/command tracking for D1 sequences
    if (host_wr_i)
    begin
      if (host_is_cmd_i)
      begin
        next_cur.await_d1_data = (host_data_i == fast_gate_pkg::CMD_WRITE_OUT);
      end
      else if (cur.await_d1_data)
      begin
        next_cur.await_d1_data = 1'b0;
        next_cur.hw_gate       = host_data_i[1];
        next_cur.hw_reset_n    = host_data_i[0];
      end
    end

    // Source select: hardware path replaces firmware when enabled
    kb_gate    = hw_gate_en ? cur.hw_gate : fw_gate_i;
    kb_reset_n = hw_rst_en ? (cur.hw_reset_n & ~fe_pulse) : fw_reset_n_i;

    // System port contributes only when enabled
    if (sys_en)
    begin
      sys_gate    = cur.sys_bits[fast_gate_pkg::SYS_GATE_BIT];
      sys_reset_n = ~sys_pulse;
    end

    // Merge both sources
    next_cur.gate_out    = kb_gate | sys_gate;
    next_cur.reset_out_n = kb_reset_n & sys_reset_n;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cur.fast_ctrl     <= fast_gate_pkg::FAST_CTRL_RESET;
      cur.sys_bits      <= fast_gate_pkg::SYS_PORT_RESET[1:0];
      cur.await_d1_data <= 1'b0;
      cur.hw_gate       <= 1'b0;
      cur.hw_reset_n    <= 1'b1;
      cur.clk_sync      <= 3'h0;
      cur.gate_out      <= 1'b0;
      cur.reset_out_n   <= 1'b1;
      cur.sys_rdata     <= fast_gate_pkg::SYS_PORT_RESET;
      cur.cfg_rdata     <= 8'h00;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign addr20_gate_out_o = cur.gate_out;
  assign cpu_reset_out_n_o = cur.reset_out_n;
  assign sys_port_rdata_o  = cur.sys_rdata;
  assign cfg_rdata_o       = cur.cfg_rdata;

endmodule : fast_gate_ctrl

// >>> dv/fast_gate_ctrl_assertions.sv
// Port checker for the fast gate and reset block.
// Assumes a controller tick every 8 system clocks and rate code 3 for pulses.
`timescale 1ns/10ps
module fast_gate_ctrl_assertions
(
  // Watched ports
  input wire logic       sys_clk_i, rst_i, host_wr_i, host_is_cmd_i, sys_port_wr_i, cfg_wr_i,
  input wire logic       fw_gate_i, fw_reset_n_i, addr20_gate_out_o, cpu_reset_out_n_o,
  input wire logic [3:0] cfg_ldev_i,
  input wire logic [7:0] host_data_i, sys_port_wdata_i, sys_port_rdata_o,
  input wire logic [7:0] cfg_index_i, cfg_wdata_i, cfg_rdata_o
);
  logic [7:0] ctrl;
  logic       armed;
  logic       here;
  logic [11:0] fe_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  assign here = cfg_ldev_i == 4'h5 && cfg_index_i == 8'hF0 && !cfg_wr_i;
  // Shadow control register and D1 arm flag
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ctrl   <= 8'h00;
      armed  <= 1'b0;
      fe_cnt <= 12'h000;
    end
    else
    begin
      if (cfg_wr_i && cfg_ldev_i == 4'h5 && cfg_index_i == 8'hF0)
        ctrl <= cfg_wdata_i & 8'hC7;
      if (host_wr_i)
        armed <= host_is_cmd_i && host_data_i == 8'hD1;
      // Cycles since a fast-rate FE command, held at zero once reset goes low
      if (host_wr_i && host_is_cmd_i && host_data_i == 8'hFE && ctrl[7:6] == 2'b11
          && ctrl[0] && !ctrl[2] && cpu_reset_out_n_o && fe_cnt == 12'h000)
        fe_cnt <= 12'h001;
      else if (fe_cnt != 12'h000 && cpu_reset_out_n_o)
        fe_cnt <= fe_cnt + 12'h001;
      else
        fe_cnt <= 12'h000;
    end
  end
  a_sys_read_fixed: assert property (sys_port_wr_i |-> ##2
    sys_port_rdata_o == {6'h09, $past(sys_port_wdata_i[1:0], 2)}) else $error("sys read");
  a_cfg_other_zero: assert property (cfg_ldev_i != 4'h5 |=>
    cfg_rdata_o == 8'h00) else $error("cfg other");
  a_cfg_read_back: assert property (here ##1 here |->
    cfg_rdata_o == ctrl) else $error("cfg read");
  a_gate_fw_only: assert property (!ctrl[1] && !ctrl[2] |=>
    addr20_gate_out_o == $past(fw_gate_i)) else $error("fw gate");
  a_reset_fw_only: assert property (!ctrl[0] && !ctrl[2] |=>
    cpu_reset_out_n_o == $past(fw_reset_n_i)) else $error("fw reset");
  a_d1_sets_gate: assert property (armed && host_wr_i && !host_is_cmd_i && ctrl[1]
    && !ctrl[2] |-> ##2 addr20_gate_out_o == $past(host_data_i[1], 2)) else $error("d1 gate");
  a_d1_sets_reset: assert property (armed && host_wr_i && !host_is_cmd_i && ctrl[0]
    && !ctrl[2] |-> ##2 cpu_reset_out_n_o == $past(host_data_i[0], 2)) else $error("d1 rst");
  a_sys_gate_high: assert property (sys_port_wr_i && ctrl[2] && sys_port_wdata_i[1]
    |-> ##2 addr20_gate_out_o) else $error("sys gate");
  // Reset must fall between 1780 and 1815 cycles after the command
  a_fe_delay_ticks: assert property (fe_cnt != 12'h000 |-> fe_cnt <= 12'h717
    && (cpu_reset_out_n_o || fe_cnt >= 12'h6F4)) else $error("fe delay");
endmodule : fast_gate_ctrl_assertions

// >>> dv/host_model.sv
// Host side: writes the controller ports and makes the controller clock.
// Assumes each write is started at a falling edge of sys_clk_i.
`timescale 1ns/10ps
module host_model
(
  // Clock
  input  wire logic       sys_clk_i,
  // Controller side
  output logic            kbc_clk_o,
  output logic            host_wr_o,
  output logic            host_is_cmd_o,
  output logic [7:0]      host_data_o
);
  // Free running controller clock, 8 system clocks a period, off phase
  initial
  begin
    kbc_clk_o     = 1'b0;
    host_wr_o     = 1'b0;
    host_is_cmd_o = 1'b0;
    host_data_o   = 8'h00;
    #3;
    forever #16 kbc_clk_o = ~kbc_clk_o;
  end
  task automatic write(input logic is_cmd, input logic [7:0] d);
    host_is_cmd_o = is_cmd;
    host_data_o   = d;
    host_wr_o     = 1'b1;
    @(negedge sys_clk_i);
    host_wr_o   = 1'b0;
    host_data_o = ~d;
    repeat (2) @(negedge sys_clk_i);
  endtask : write
endmodule : host_model

// >>> dv/tb.sv
// Self-checking bench for the fast gate and reset block.
// Assumes host_model drives the controller ports; rate codes 3 and 0 for pulse timing.
`timescale 1ns/10ps
module tb;
  logic       sys_clk_i = 1'b0, rst_i = 1'b1, kbc_clk_i, host_wr_i, host_is_cmd_i;
  logic       sys_port_wr_i = 1'b0, cfg_wr_i = 1'b0, fw_gate_i = 1'b0, fw_reset_n_i = 1'b1;
  logic       addr20_gate_out_o, cpu_reset_out_n_o;
  logic [3:0] cfg_ldev_i = 4'h5;
  logic [7:0] host_data_i, sys_port_rdata_o, cfg_rdata_o, cfg_index_i = 8'hF0;
  logic [7:0] sys_port_wdata_i = 8'h00, cfg_wdata_i = 8'h00;
  logic [7:0] seq [3] = '{8'h02, 8'h01, 8'h03};
  int         fails = 0, cmp_count = 0, n;
  always #2 sys_clk_i = ~sys_clk_i;
  host_model host (.sys_clk_i, .kbc_clk_o(kbc_clk_i), .host_wr_o(host_wr_i),
    .host_is_cmd_o(host_is_cmd_i), .host_data_o(host_data_i));
  fast_gate_ctrl uut (.sys_clk_i, .rst_i, .kbc_clk_i, .host_wr_i, .host_is_cmd_i, .host_data_i,
    .sys_port_wr_i, .sys_port_wdata_i, .sys_port_rdata_o, .cfg_wr_i, .cfg_ldev_i, .cfg_index_i,
    .cfg_wdata_i, .cfg_rdata_o, .fw_gate_i, .fw_reset_n_i, .addr20_gate_out_o, .cpu_reset_out_n_o);
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask : tick
  task automatic cfg(input logic [3:0] ld, input logic [7:0] d);
    cfg_ldev_i  = ld;
    cfg_wdata_i = d;
    cfg_wr_i    = 1'b1;
    tick(1);
    cfg_wr_i = 1'b0;
    tick(2);
  endtask : cfg
  task automatic sys(input logic [7:0] d);
    sys_port_wdata_i = d;
    sys_port_wr_i    = 1'b1;
    tick(1);
    sys_port_wr_i = 1'b0;
    tick(2);
  endtask : sys
  task automatic pulse_check(input string name, input int tpu);
    int d;
    int p;
    // Eight system clocks per controller tick in the host model
    d = fast_gate_pkg::DELAY_US * tpu * 8;
    p = fast_gate_pkg::PULSE_US * tpu * 8;
    for (n = 0; n < 4000 && cpu_reset_out_n_o === 1'b1; n++) tick(1);
    check(name, 8'(n >= d - 22 && n <= d + 23), 8'h01);
    for (n = 0; n < 2000 && cpu_reset_out_n_o === 1'b0; n++) tick(1);
    check(name, 8'(n >= p - 13 && n <= p + 17), 8'h01);
  endtask : pulse_check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    print_verdict();
  end
  initial
  begin
    tick(10);
    rst_i = 1'b0;
    tick(2);
    check("sys reset", sys_port_rdata_o, 8'h24);
    check("ctrl reset", cfg_rdata_o, 8'h00);
    fw_gate_i    = 1'b1;
    fw_reset_n_i = 1'b0;
    tick(2);
    check("fw path", {6'h0, addr20_gate_out_o, cpu_reset_out_n_o}, 8'h02);
    fw_reset_n_i = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      cfg(4'h5, {r[1:0], 6'h3F});
      check("ctrl rate", cfg_rdata_o, {r[1:0], 6'h07});
    end
    check("hw gate", {7'h0, addr20_gate_out_o}, 8'h00);
    cfg(4'h4, 8'h00);
    check("other dev", cfg_rdata_o, 8'h00);
    cfg_ldev_i = 4'h5;
    tick(2);
    check("ctrl kept", cfg_rdata_o, 8'hC7);
    cfg(4'h5, 8'hC3);
    fw_reset_n_i = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      host.write(1'b1, 8'hD1);
      host.write(1'b0, seq[i]);
      check("d1 out", {6'h0, addr20_gate_out_o, cpu_reset_out_n_o}, seq[i]);
    end
    host.write(1'b1, 8'hD1);
    host.write(1'b1, 8'h20);
    host.write(1'b0, 8'h00);
    check("d1 cancel", {7'h0, addr20_gate_out_o}, 8'h01);
    host.write(1'b1, 8'hFE);
    pulse_check("kb pulse", 16);
    fw_gate_i    = 1'b0;
    fw_reset_n_i = 1'b1;
    cfg(4'h5, 8'h03);
    host.write(1'b1, 8'hFE);
    pulse_check("rate pulse", 6);
    cfg(4'h5, 8'h02);
    host.write(1'b1, 8'hFE);
    cfg(4'h5, 8'h03);
    tick(700);
    check("fe off", {7'h0, cpu_reset_out_n_o}, 8'h01);
    cfg(4'h5, 8'hC0);
    sys(8'h02);
    check("sys off", {7'h0, addr20_gate_out_o}, 8'h00);
    check("sys read", sys_port_rdata_o, 8'h26);
    cfg(4'h5, 8'hC4);
    check("sys gate", {7'h0, addr20_gate_out_o}, 8'h01);
    fw_gate_i = 1'b1;
    sys(8'h00);
    check("merge", {7'h0, addr20_gate_out_o}, 8'h01);
    fw_gate_i = 1'b0;
    tick(2);
    check("sys low", {7'h0, addr20_gate_out_o}, 8'h00);
    sys(8'h02);
    check("sys high", {7'h0, addr20_gate_out_o}, 8'h01);
    sys(8'h01);
    pulse_check("sys pulse", 16);
    sys(8'h00);
    sys(8'h01);
    pulse_check("sys again", 16);
    print_verdict();
  end
endmodule : tb
bind fast_gate_ctrl fast_gate_ctrl_assertions chk (.sys_clk_i, .rst_i, .host_wr_i,
  .host_is_cmd_i, .sys_port_wr_i, .cfg_wr_i, .fw_gate_i, .fw_reset_n_i, .addr20_gate_out_o,
  .cpu_reset_out_n_o, .cfg_ldev_i, .host_data_i, .sys_port_wdata_i, .sys_port_rdata_o,
  .cfg_index_i, .cfg_wdata_i, .cfg_rdata_o);
